// file: rtl/priv_pkg.sv
// Shared constants and decode functions for the privileged register unit
package priv_pkg;
  // ==========================================================
  // Operation codes and access modes
  localparam logic [7:0] OPC_WRITE_PR = 8'hda;
  localparam logic [7:0] OPC_READ_PR = 8'hdb;
  localparam logic [1:0] MODE_KERNEL = 2'h0;
  // ==========================================================
  // Privileged register numbers
  localparam logic [5:0] RN_KSP = 6'h00;
  localparam logic [5:0] RN_ISP = 6'h04;
  localparam logic [5:0] RN_IPL = 6'h12;
  localparam logic [5:0] RN_SIRR = 6'h14;
  localparam logic [5:0] RN_SISR = 6'h15;
  localparam logic [5:0] RN_NICR = 6'h19;
  localparam logic [5:0] RN_ICR = 6'h1a;
  localparam logic [5:0] RN_TXDB = 6'h23;
  localparam logic [5:0] RN_TBIA = 6'h39;
  localparam logic [5:0] RN_TBIS = 6'h3a;
  localparam logic [5:0] RN_SID = 6'h3e;
  localparam logic [5:0] RN_TRANSLATION_PROBE_REGISTER = 6'h3f;
  // ==========================================================
  // Bus-only registers (word index) and field positions
  localparam logic [6:0] WB_IDX_CTRL = 7'h40;
  localparam logic [6:0] WB_IDX_STAT = 7'h41;
  localparam int CTRL_CACHE_EN = 0;
  localparam int CTRL_ERR_EN = 1;
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_V = 1;
  localparam int CC_C = 0;
  // ==========================================================
  // Reset values, levels and fault codes
  localparam logic [4:0] IPL_RST = 5'h1f;
  localparam logic [4:0] ERR_IPL = 5'h1d;
  localparam logic [1:0] FLT_NONE = 2'h0;
  localparam logic [1:0] FLT_RSV_INSTR = 2'h1;
  localparam logic [1:0] FLT_RSV_OPND = 2'h2;
  localparam logic [1:0] FLT_ABORT = 2'h3;
  // ==========================================================
  // Register number decoding
  function automatic logic reg_exists(input logic [31:0] rn);
    if (rn > 32'h0000003f) return 1'b0;
    case (rn[5:0])
      6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d,
      6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h18, 6'h19, 6'h1a, 6'h1b,
      6'h20, 6'h21, 6'h22, 6'h23, 6'h38, 6'h39, 6'h3a, 6'h3d, 6'h3e, 6'h3f: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic reg_read_only(input logic [5:0] rn);
    return (rn == RN_ICR) || (rn == RN_SID);
  endfunction
  function automatic logic reg_write_only(input logic [5:0] rn);
    return (rn == RN_SIRR) || (rn == RN_NICR) || (rn == RN_TXDB) || (rn == RN_TBIA) ||
           (rn == RN_TBIS) || (rn == RN_TRANSLATION_PROBE_REGISTER);
  endfunction
endpackage

// file: rtl/prs_mem.sv
// Storage array for privileged registers without dedicated logic
`timescale 1ns/1ps
module prs_mem
  import priv_pkg::*;
#(
  parameter int AW = 6,
  parameter int DW = 32
)
(
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [2**AW];

  // ==========================================================
  // Write port and registered read port
  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      if (we_i)
      begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end
endmodule // prs_mem

// file: rtl/irq_arbiter.sv
// Priority selection of pending interrupt levels against current priority
`timescale 1ns/1ps
module irq_arbiter
  import priv_pkg::*;
(
  input wire logic [15:0] hw_irq_i,
  input wire logic [15:0] sw_req_i,
  input wire logic err_req_i,
  input wire logic [4:0] ipl_i,
  output logic [4:0] lvl_o,
  output logic valid_o
);
  logic [31:0] req;

  // Hardware levels sit above the software levels; level 0 never requests
  assign req = {hw_irq_i, sw_req_i[15:1], 1'b0} | (32'h1 << ERR_IPL) & {32{err_req_i}};

  // Highest requesting level wins
  always_comb
  begin
    lvl_o = 5'h00;
    for (int i = 1; i < 32; i++)
    begin
      if (req[i])
      begin
        lvl_o = 5'(i);
      end
    end
    valid_o = lvl_o > ipl_i;
  end
endmodule // irq_arbiter

// file: rtl/priv_reg_unit.sv
// Privileged register write/read, stack pointer images and interrupt sequencing
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module priv_reg_unit
  import priv_pkg::*;
#(
  parameter int PA_W = 30,
  parameter logic [31:0] SYS_ID = 32'h5a00_0001 // Arbitrary identification value
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic op_valid_i,
  input wire logic [7:0] op_code_i,
  input wire logic [31:0] op_src_i,
  input wire logic [31:0] op_regnum_i,
  input wire logic [1:0] mode_i,
  input wire logic is_flag_i,
  input wire logic [3:0] cc_i,
  input wire logic tb_probe_hit_i,
  input wire logic err_fatal_i,
  input wire logic err_soft_i,
  output logic busy_o,
  output logic op_done_o,
  output logic [1:0] op_fault_o,
  output logic [31:0] op_dst_o,
  output logic [3:0] cc_o,
  output logic tb_inval_all_o,
  output logic tb_inval_one_o,
  input wire logic gr_sp_we_i,
  input wire logic [31:0] gr_sp_dat_i,
  output logic [31:0] sp_o,
  input wire logic ctx_load_i,
  input wire logic [127:0] ctx_sp_i,
  output logic ctx_ready_o,
  input wire logic [15:0] hw_irq_i,
  input wire logic boundary_i,
  input wire logic io_inflight_i,
  output logic boundary_ack_o,
  output logic take_irq_o,
  output logic [4:0] irq_level_o,
  output logic [4:0] priority_level_o,
  input wire logic [PA_W-1:0] pa_i,
  output logic cache_bypass_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_RD_WAIT, ST_WB_WAIT} st_t;

  typedef struct packed {
    st_t st;
    logic [4:0][31:0] sp;
    logic [4:0] priority_level;
    logic [15:0] sisr;
    logic err_pend;
    logic cache_en;
    logic err_en;
    logic [1:0] last_fault;
    logic busy;
    logic done;
    logic [1:0] fault;
    logic [31:0] dst;
    logic [3:0] cc;
    logic ack;
    logic [31:0] wb_dat;
    logic bnd_ack;
    logic take;
    logic [4:0] irq_lvl;
    logic tbia;
    logic tbis;
    logic [31:0] sp_out;
    logic ctx_ready;
    logic bypass;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic mem_we;
  logic [5:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic [5:0] mem_raddr;
  logic [31:0] mem_q;
  logic [4:0] arb_lvl;
  logic arb_valid;
  logic [6:0] wb_idx;

  assign wb_idx = wb_adr_i[8:2];

  // Image index equals the stack pointer's register number
  function automatic logic [2:0] sp_sel(input logic [1:0] mode, input logic on_is);
    return on_is ? 3'h4 : {1'b0, mode};
  endfunction

  // Registers held in dedicated logic rather than the storage array
  function automatic logic is_internal(input logic [5:0] rn);
    return (rn <= RN_ISP) || (rn == RN_IPL) || (rn == RN_SISR) || (rn == RN_SID);
  endfunction

  // ==========================================================
  // Submodules
  prs_mem #(.AW(6), .DW(32)) u_mem (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(mem_raddr),
    .rdata_o(mem_q)
  );

  irq_arbiter u_arb (
    .hw_irq_i(hw_irq_i),
    .sw_req_i(s_r.sisr),
    .err_req_i(s_r.err_pend & s_r.err_en),
    .ipl_i(s_r.priority_level),
    .lvl_o(arb_lvl),
    .valid_o(arb_valid)
  );

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    logic w_en;
    logic [5:0] w_idx;
    logic [31:0] w_dat;
    logic [5:0] rn;
    logic [31:0] rd_val;
    w_en = 1'b0;
    w_idx = 6'h00;
    w_dat = 32'h0000_0000;
    rn = op_regnum_i[5:0];
    rd_val = 32'h0000_0000;
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.ack = 1'b0;
    s_nxt.bnd_ack = 1'b0;
    s_nxt.take = 1'b0;
    s_nxt.tbia = 1'b0;
    s_nxt.tbis = 1'b0;
    mem_we = 1'b0;
    mem_waddr = 6'h00;
    mem_wdata = 32'h0000_0000;
    mem_raddr = (op_valid_i && s_r.st == ST_IDLE) ? rn : wb_idx[5:0];
    // Context load fills scratchpads; no memory copy used
    if (ctx_load_i && s_r.ctx_ready)
    begin
      for (int i = 0; i < 4; i++)
      begin
        s_nxt.sp[i] = ctx_sp_i[32*i +: 32];
      end
    end
    if (gr_sp_we_i)
    begin
      s_nxt.sp[sp_sel(mode_i, is_flag_i)] = gr_sp_dat_i;
    end
    case (s_r.st)
      ST_IDLE:
      begin
        if (op_valid_i)
        begin
          s_nxt.cc = cc_i;
          s_nxt.fault = FLT_NONE;
          if (mode_i != MODE_KERNEL)
          begin
            s_nxt.fault = FLT_RSV_INSTR;
          end
          else if (!reg_exists(op_regnum_i))
          begin
            s_nxt.fault = FLT_RSV_OPND;
          end
          else if ((op_code_i == OPC_WRITE_PR && reg_read_only(rn)) ||
                   (op_code_i == OPC_READ_PR && reg_write_only(rn)))
          begin
            s_nxt.fault = FLT_RSV_OPND;
          end
          else if (err_fatal_i)
          begin
            s_nxt.fault = FLT_ABORT;
          end
          if (s_nxt.fault != FLT_NONE || (op_code_i != OPC_WRITE_PR &&
              op_code_i != OPC_READ_PR))
          begin
            s_nxt.done = 1'b1;
            s_nxt.last_fault = s_nxt.fault;
          end
          else if (op_code_i == OPC_WRITE_PR)
          begin
            w_en = 1'b1;
            w_idx = rn;
            w_dat = op_src_i;
            s_nxt.done = 1'b1;
            s_nxt.cc[CC_N] = op_src_i[31];
            s_nxt.cc[CC_Z] = (op_src_i == 32'h0000_0000);
            s_nxt.cc[CC_V] = (rn == RN_TRANSLATION_PROBE_REGISTER) ? tb_probe_hit_i : 1'b0;
          end
          else if (is_internal(rn))
          begin
            // Image named by the register number read straight from the same storage
            if (rn <= RN_ISP)
            begin
              rd_val = s_nxt.sp[rn[2:0]];
            end
            else if (rn == RN_IPL)
            begin
              rd_val = {27'h0000000, s_r.priority_level};
            end
            else if (rn == RN_SISR)
            begin
              rd_val = {16'h0000, s_r.sisr};
            end
            else
            begin
              rd_val = SYS_ID;
            end
            s_nxt.dst = rd_val;
            s_nxt.done = 1'b1;
            s_nxt.cc[CC_N] = rd_val[31];
            s_nxt.cc[CC_Z] = (rd_val == 32'h0000_0000);
            s_nxt.cc[CC_V] = 1'b0;
          end
          else
          begin
            s_nxt.st = ST_RD_WAIT;
          end
        end
        // Bus access when the datapath is quiet; skip the cycle of our own ack
        else if (wb_cyc_i && wb_stb_i && !s_r.ack)
        begin
          s_nxt.wb_dat = 32'h0000_0000;
          if (wb_idx == WB_IDX_CTRL)
          begin
            s_nxt.ack = 1'b1;
            s_nxt.wb_dat = {30'h00000000, s_r.err_en, s_r.cache_en};
            if (wb_we_i && wb_sel_i == 4'hf)
            begin
              s_nxt.cache_en = wb_dat_i[CTRL_CACHE_EN];
              s_nxt.err_en = wb_dat_i[CTRL_ERR_EN];
            end
          end
          else if (wb_idx == WB_IDX_STAT)
          begin
            s_nxt.ack = 1'b1;
            s_nxt.wb_dat = {19'h00000, s_r.priority_level, 5'h00, s_r.last_fault, s_r.err_pend};
          end
          else if (!reg_exists({25'h0000000, wb_idx}) || wb_we_i)
          begin
            s_nxt.ack = 1'b1;
            if (wb_we_i && wb_sel_i == 4'hf && reg_exists({25'h0000000, wb_idx}) &&
                !reg_read_only(wb_idx[5:0]))
            begin
              w_en = 1'b1;
              w_idx = wb_idx[5:0];
              w_dat = wb_dat_i;
            end
          end
          else if (wb_idx[5:0] <= RN_ISP)
          begin
            s_nxt.ack = 1'b1;
            s_nxt.wb_dat = s_r.sp[wb_idx[2:0]];
          end
          else if (wb_idx[5:0] == RN_IPL || wb_idx[5:0] == RN_SISR || wb_idx[5:0] == RN_SID)
          begin
            s_nxt.ack = 1'b1;
            s_nxt.wb_dat = (wb_idx[5:0] == RN_IPL) ? {27'h0000000, s_r.priority_level} :
                           (wb_idx[5:0] == RN_SISR) ? {16'h0000, s_r.sisr} : SYS_ID;
          end
          else
          begin
            s_nxt.st = ST_WB_WAIT;
          end
        end
      end
      ST_RD_WAIT:
      begin
        s_nxt.st = ST_IDLE;
        s_nxt.done = 1'b1;
        s_nxt.dst = mem_q;
        s_nxt.cc[CC_N] = mem_q[31];
        s_nxt.cc[CC_Z] = (mem_q == 32'h0000_0000);
        s_nxt.cc[CC_V] = 1'b0;
      end
      ST_WB_WAIT:
      begin
        s_nxt.st = ST_IDLE;
        s_nxt.ack = 1'b1;
        s_nxt.wb_dat = mem_q;
      end
      default:
      begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    // Level requests compared at each boundary
    if (boundary_i)
    begin
      s_nxt.bnd_ack = 1'b1;
      // No interrupt after an I/O-space access
      if (arb_valid && !io_inflight_i)
      begin
        s_nxt.take = 1'b1;
        s_nxt.irq_lvl = arb_lvl;
        s_nxt.priority_level = arb_lvl;
        if (arb_lvl < 5'h10)
        begin
          s_nxt.sisr[arb_lvl[3:0]] = 1'b0;
        end
        if (arb_lvl == ERR_IPL)
        begin
          s_nxt.err_pend = 1'b0;
        end
      end
    end
    // Errors post a request; set wins over clear
    if (err_soft_i || err_fatal_i)
    begin
      s_nxt.err_pend = 1'b1;
    end
    if (w_en)
    begin
      if (w_idx <= RN_ISP)
      begin
        s_nxt.sp[w_idx[2:0]] = w_dat;
      end
      else if (w_idx == RN_IPL)
      begin
        s_nxt.priority_level = w_dat[4:0];
      end
      else if (w_idx == RN_SIRR)
      begin
        if (w_dat[3:0] != 4'h0)
        begin
          s_nxt.sisr[w_dat[3:0]] = 1'b1;
        end
      end
      else if (w_idx == RN_SISR)
      begin
        s_nxt.sisr = {w_dat[15:1], 1'b0};
      end
      else
      begin
        s_nxt.tbia = (w_idx == RN_TBIA);
        s_nxt.tbis = (w_idx == RN_TBIS);
        mem_we = 1'b1;
        mem_waddr = w_idx;
        mem_wdata = w_dat;
      end
    end
    s_nxt.busy = (s_nxt.st != ST_IDLE);
    s_nxt.sp_out = s_nxt.sp[sp_sel(mode_i, is_flag_i)];
    // Hold context switch while the error request is owed
    s_nxt.ctx_ready = !(s_nxt.err_pend && s_nxt.err_en && (ERR_IPL > s_nxt.priority_level));
    // I/O half of physical space never cached
    s_nxt.bypass = !s_r.cache_en || pa_i[PA_W-1];
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r <= '0;
      s_r.priority_level <= IPL_RST;
      s_r.ctx_ready <= 1'b1;
      s_r.bypass <= 1'b1;
    end
    else if (ce_i)
    begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o = s_r.wb_dat;
  assign wb_ack_o = s_r.ack;
  assign busy_o = s_r.busy;
  assign op_done_o = s_r.done;
  assign op_fault_o = s_r.fault;
  assign op_dst_o = s_r.dst;
  assign cc_o = s_r.cc;
  assign tb_inval_all_o = s_r.tbia;
  assign tb_inval_one_o = s_r.tbis;
  assign sp_o = s_r.sp_out;
  assign ctx_ready_o = s_r.ctx_ready;
  assign boundary_ack_o = s_r.bnd_ack;
  assign take_irq_o = s_r.take;
  assign irq_level_o = s_r.irq_lvl;
  assign priority_level_o = s_r.priority_level;
  assign cache_bypass_o = s_r.bypass;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  sequence s_start;
    s_r.st == ST_IDLE && op_valid_i && ce_i;
  endsequence
  sequence s_kwrite_ipl;
    s_start and (op_code_i == OPC_WRITE_PR && mode_i == MODE_KERNEL &&
    op_regnum_i == {26'h0000000, RN_IPL} && !err_fatal_i);
  endsequence

  property p_rsv_instr;
    s_start and (mode_i != MODE_KERNEL) |=> op_done_o && op_fault_o == FLT_RSV_INSTR;
  endproperty
  a_rsv_instr: assert property (p_rsv_instr) else $error("user mode not faulted");
  property p_fault_keeps_ipl;
    s_start and (mode_i != MODE_KERNEL) and (op_code_i == OPC_WRITE_PR) and !boundary_i
      |=> priority_level_o == $past(priority_level_o);
  endproperty
  a_fault_keeps_ipl: assert property (p_fault_keeps_ipl) else $error("faulted write changed reg");
  property p_fault_keeps_cc;
    s_start and (mode_i != MODE_KERNEL) |=> cc_o == $past(cc_i);
  endproperty
  a_fault_keeps_cc: assert property (p_fault_keeps_cc) else $error("flags changed on fault");
  property p_ipl_write;
    s_kwrite_ipl and !boundary_i |=> op_done_o && op_fault_o == FLT_NONE &&
      priority_level_o == $past(op_src_i[4:0]);
  endproperty
  a_ipl_write: assert property (p_ipl_write) else $error("register write lost");
  property p_cc_write;
    s_kwrite_ipl |=> cc_o[CC_Z] == ($past(op_src_i) == 32'h0) && !cc_o[CC_V] &&
      cc_o[CC_N] == ($past(op_src_i) > 32'h7fffffff) && cc_o[CC_C] == $past(cc_i[CC_C]);
  endproperty
  a_cc_write: assert property (p_cc_write) else $error("flags wrong after write");
  property p_bad_regnum;
    s_start and (mode_i == MODE_KERNEL) and (op_regnum_i > 32'h3f)
      |=> op_done_o && op_fault_o == FLT_RSV_OPND;
  endproperty
  a_bad_regnum: assert property (p_bad_regnum) else $error("bad number not faulted");
  property p_read_only;
    s_start and (mode_i == MODE_KERNEL) and (op_code_i == OPC_WRITE_PR) and
      (op_regnum_i == {26'h0000000, RN_SID}) |=> op_fault_o == FLT_RSV_OPND;
  endproperty
  a_read_only: assert property (p_read_only) else $error("read-only write accepted");
  property p_take;
    boundary_i && arb_valid && !io_inflight_i |=> boundary_ack_o && take_irq_o &&
      irq_level_o == $past(arb_lvl) ##1 !take_irq_o || $past(boundary_i);
  endproperty
  a_take: assert property (p_take) else $error("enabled interrupt not taken");
  property p_io_hold;
    boundary_i && io_inflight_i |=> boundary_ack_o && !take_irq_o;
  endproperty
  a_io_hold: assert property (p_io_hold) else $error("interrupt after I/O access");
  property p_bypass;
    pa_i[PA_W-1] |=> cache_bypass_o;
  endproperty
  a_bypass: assert property (p_bypass) else $error("I/O reference cached");
endmodule // priv_reg_unit

// file: verif/irq_source_model.sv
// Interrupt source model: level requests that withdraw once served
`timescale 1ns/1ps
module irq_source_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] want_i,
  input wire logic take_i,
  input wire logic [4:0] lvl_i,
  output logic [15:0] hw_irq_o
);
  logic [15:0] served_r;
  // ==========================================
  // Request levels
  // level held until served, then dropped until want_i falls
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      served_r <= 16'h0000;
      hw_irq_o <= 16'h0000;
    end
    else
    begin
      served_r <= (served_r | ((take_i && lvl_i[4]) ? (16'h0001 << lvl_i[3:0]) : 16'h0000))
        & want_i;
      hw_irq_o <= want_i & ~served_r; // Served requests drop
    end
  end
endmodule // irq_source_model

// file: verif/tb_priv_reg_unit.sv
// Testbench for the privileged register unit
`timescale 1ns/1ps
module tb_priv_reg_unit
  import priv_pkg::*;
;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, op_valid_i, is_flag_i;
  logic tb_probe_hit_i, err_fatal_i, err_soft_i, busy_o, op_done_o, tb_inval_all_o;
  logic tb_inval_one_o, gr_sp_we_i, ctx_load_i, ctx_ready_o, boundary_i, io_inflight_i;
  logic boundary_ack_o, take_irq_o, cache_bypass_o;
  logic [8:0] wb_adr_i;
  logic [3:0] wb_sel_i, cc_i, cc_o;
  logic [31:0] wb_dat_i, wb_dat_o, op_src_i, op_regnum_i, op_dst_o, gr_sp_dat_i, sp_o, rd;
  logic [7:0] op_code_i;
  logic [1:0] mode_i, op_fault_o;
  logic [127:0] ctx_sp_i;
  logic [15:0] hw_irq_i, want;
  logic [4:0] irq_level_o, priority_level_o;
  logic [29:0] pa_i;
  int n_mismatch = 0;
  int num_checks = 0;
  // ==========================================
  // Design and interrupt source
  priv_reg_unit dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
    .op_src_i(op_src_i), .op_regnum_i(op_regnum_i), .mode_i(mode_i), .is_flag_i(is_flag_i),
    .cc_i(cc_i), .tb_probe_hit_i(tb_probe_hit_i), .err_fatal_i(err_fatal_i),
    .err_soft_i(err_soft_i), .busy_o(busy_o), .op_done_o(op_done_o), .op_fault_o(op_fault_o),
    .op_dst_o(op_dst_o), .cc_o(cc_o), .tb_inval_all_o(tb_inval_all_o),
    .tb_inval_one_o(tb_inval_one_o), .gr_sp_we_i(gr_sp_we_i), .gr_sp_dat_i(gr_sp_dat_i),
    .sp_o(sp_o), .ctx_load_i(ctx_load_i), .ctx_sp_i(ctx_sp_i), .ctx_ready_o(ctx_ready_o),
    .hw_irq_i(hw_irq_i), .boundary_i(boundary_i), .io_inflight_i(io_inflight_i),
    .boundary_ack_o(boundary_ack_o), .take_irq_o(take_irq_o), .irq_level_o(irq_level_o),
    .priority_level_o(priority_level_o), .pa_i(pa_i), .cache_bypass_o(cache_bypass_o)
  );
  irq_source_model src (.clk_i(clk_i), .rst_i(rst_i), .want_i(want), .take_i(take_irq_o),
    .lvl_i(irq_level_o), .hw_irq_o(hw_irq_i));
  // ==========================================
  // Checking and closing
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // Access tasks
  task automatic wb(input logic we, input logic [8:0] adr, input logic [31:0] dat);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && k < 20)
    begin
      @(posedge clk_i);
      k++;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  task automatic op(input logic [7:0] c, input logic [31:0] rn, input logic [31:0] s,
    input logic [1:0] m);
    int k;
    k = 0;
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_code_i <= c;
    op_regnum_i <= rn;
    op_src_i <= s;
    mode_i <= m;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    #1;
    while (op_done_o !== 1'b1 && k < 20)
    begin
      chk("busy", busy_o, 1'b1);
      @(posedge clk_i);
      #1;
      k++;
    end
    if (op_done_o !== 1'b1)
    begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  task automatic bnd(input logic tk, input logic [4:0] lvl);
    @(posedge clk_i);
    boundary_i <= 1'b1;
    @(posedge clk_i);
    boundary_i <= 1'b0;
    #1;
    chk("bnd_ack", boundary_ack_o, 1'b1);
    chk("take", take_irq_o, tk);
    if (tk)
      chk("level", irq_level_o, lvl);
  endtask
  // ==========================================
  // Clock, watchdog and scenarios
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    {rst_i, ce_i} = 2'b11;
    {wb_cyc_i, wb_stb_i, wb_we_i, op_valid_i, is_flag_i, tb_probe_hit_i} = 6'h00;
    {err_fatal_i, err_soft_i, gr_sp_we_i, ctx_load_i, boundary_i, io_inflight_i} = 6'h00;
    {wb_adr_i, wb_dat_i, op_src_i, op_regnum_i, gr_sp_dat_i, ctx_sp_i} = '0;
    {op_code_i, mode_i, want, pa_i} = '0;
    wb_sel_i = 4'hf;
    cc_i = 4'h3;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("ipl_rst", priority_level_o, IPL_RST);
    chk("byp_rst", cache_bypass_o, 1'b1);
    op(OPC_WRITE_PR, 32'(RN_IPL), 32'h0, MODE_KERNEL);
    chk("cc_zero", cc_o, 4'h5);
    chk("ipl_wr", priority_level_o, 5'h00);
    op(OPC_WRITE_PR, 32'(RN_KSP), 32'h1234_5678, MODE_KERNEL);
    chk("cc_pos", cc_o, 4'h1);
    @(posedge clk_i);
    #1;
    chk("sp_img", sp_o, 32'h1234_5678);
    op(OPC_READ_PR, 32'(RN_KSP), 32'h0, MODE_KERNEL);
    chk("ksp_rd", op_dst_o, 32'h1234_5678);
    // Faulting writes leave target and flags alone
    op(OPC_WRITE_PR, 32'(RN_IPL), 32'h1f, 2'h3);
    chk("f_mode", op_fault_o, FLT_RSV_INSTR);
    chk("cc_keep", cc_o, 4'h3);
    op(OPC_WRITE_PR, 32'h0000_0112, 32'h1f, MODE_KERNEL);
    chk("f_none", op_fault_o, FLT_RSV_OPND);
    op(OPC_WRITE_PR, 32'(RN_SID), 32'h1f, MODE_KERNEL);
    chk("f_ro", op_fault_o, FLT_RSV_OPND);
    chk("ipl_kept", priority_level_o, 5'h00);
    tb_probe_hit_i <= 1'b1;
    op(OPC_WRITE_PR, 32'(RN_TRANSLATION_PROBE_REGISTER), 32'h8000_0000, MODE_KERNEL);
    chk("cc_probe", cc_o, 4'hb);
    // Priority lowering, software requests and I/O hold-off
    op(OPC_WRITE_PR, 32'(RN_IPL), 32'h1f, MODE_KERNEL);
    want <= 16'h0001;
    bnd(1'b0, 5'h00);
    op(OPC_WRITE_PR, 32'(RN_IPL), 32'h0f, MODE_KERNEL);
    bnd(1'b1, 5'h10);
    bnd(1'b0, 5'h00);
    op(OPC_WRITE_PR, 32'(RN_IPL), 32'h0, MODE_KERNEL);
    op(OPC_WRITE_PR, 32'(RN_SIRR), 32'h3, MODE_KERNEL);
    bnd(1'b1, 5'h03);
    want <= 16'h0003;
    io_inflight_i <= 1'b1;
    bnd(1'b0, 5'h00);
    io_inflight_i <= 1'b0;
    bnd(1'b1, 5'h11);
    // Bus registers, cache bypass and error request
    wb(1'b1, 9'h100, 32'h3);
    wb(1'b0, 9'h100, 32'h0);
    chk("ctrl_rd", rd, 32'h3);
    wb(1'b0, 9'h1fc, 32'h0);
    chk("unmapped", rd, 32'h0);
    pa_i <= 30'h2000_0000;
    repeat (2) @(posedge clk_i);
    #1;
    chk("byp_io", cache_bypass_o, 1'b1);
    pa_i <= 30'h0000_0100;
    repeat (2) @(posedge clk_i);
    #1;
    chk("byp_mem", cache_bypass_o, 1'b0);
    err_soft_i <= 1'b1;
    @(posedge clk_i);
    err_soft_i <= 1'b0;
    bnd(1'b1, ERR_IPL);
    // Context load, interrupt stack image, invalidates and array reads
    ctx_sp_i <= {32'h0000_0400, 32'h0000_0300, 32'h0000_0200, 32'h0000_0100};
    ctx_load_i <= 1'b1;
    @(posedge clk_i);
    ctx_load_i <= 1'b0;
    op(OPC_READ_PR, 32'h1, 32'h0, MODE_KERNEL);
    chk("ctx_sp1", op_dst_o, 32'h0000_0200);
    is_flag_i <= 1'b1;
    op(OPC_WRITE_PR, 32'(RN_ISP), 32'h0000_4000, MODE_KERNEL);
    chk("isp_img", sp_o, 32'h0000_4000);
    is_flag_i <= 1'b0;
    op(OPC_WRITE_PR, 32'(RN_TBIA), 32'h0, MODE_KERNEL);
    chk("tbia", tb_inval_all_o, 1'b1);
    op(OPC_WRITE_PR, 32'(RN_TBIS), 32'h0, MODE_KERNEL);
    chk("tbis", {tb_inval_all_o, tb_inval_one_o}, 2'b01);
    op(OPC_WRITE_PR, 32'h8, 32'h0000_1000, MODE_KERNEL);
    op(OPC_READ_PR, 32'h8, 32'h0, MODE_KERNEL);
    chk("arr_rd", op_dst_o, 32'h0000_1000);
    wb(1'b0, 9'h0fc, 32'h0);
    chk("arr_wb", rd, 32'h8000_0000);
    // Fatal error aborts, holds context switch until its interrupt is taken
    op(OPC_WRITE_PR, 32'(RN_IPL), 32'h0, MODE_KERNEL);
    err_fatal_i <= 1'b1;
    op(OPC_WRITE_PR, 32'(RN_IPL), 32'h1f, MODE_KERNEL);
    err_fatal_i <= 1'b0;
    chk("f_abort", op_fault_o, FLT_ABORT);
    chk("ipl_abort", priority_level_o, 5'h00);
    chk("ctx_hold", ctx_ready_o, 1'b0);
    bnd(1'b1, ERR_IPL);
    chk("ctx_free", ctx_ready_o, 1'b1);
    print_verdict();
  end
endmodule // tb_priv_reg_unit
